//--- rtl/micic_pkg.sv
// constants and types shared by the interrupt controller files
package micic_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_INT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIPH_FLAG = 8'h04;
  localparam logic [7:0] OFS_PERIPH_ENABLE = 8'h08;
  localparam logic [7:0] OFS_OPTION = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ENTRY_COUNT = 8'h14;
  // int_control_reg fields
  localparam int INT_GIE = 7;
  localparam int INT_PEIE = 6;
  localparam int INT_TIMER0_OVF_ENABLE = 5;
  localparam int INT_EXTE = 4;
  localparam int INT_PCE = 3;
  localparam int INT_T0F = 2;
  localparam int INT_EXTF = 1;
  localparam int INT_PCF = 0;
  // periph_flag_reg / periph_enable_reg fields
  localparam int PF_TIMER1 = 0;
  localparam int PF_TIMER2 = 1;
  localparam int PF_CCP = 2;
  localparam int PF_SSP = 3;
  localparam int PF_ADC = 6;
  localparam int PF_LCD = 7;
  localparam logic [7:0] PF_IMPL_MASK = 8'hCF;
  // option register field
  localparam int OPT_EDGE = 6;
  // status register fields
  localparam int ST_VREQ = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_WAKE = 2;
  localparam int ST_PEND = 3;
  // reset values
  localparam logic [7:0] INT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PERIPH_FLAG_RESET = 8'h00;
  localparam logic [7:0] PERIPH_ENABLE_RESET = 8'h00;
  localparam logic EDGE_SEL_RESET = 1'b1;
  localparam logic [7:0] ENTRY_COUNT_RESET = 8'h00;
  // interrupt vector
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int ICYC_NS = 80;
  localparam int ICYC_CLKS = ICYC_NS * CLK_MHZ / 1000;
  localparam int LAT_STAGES = 3;
  typedef logic [1:0] micic_qcnt_t;
endpackage : micic_pkg

//--- rtl/micic_evt_if.sv
// event strobes from the source detector to the flag logic
interface micic_evt_if;
  logic ext_evt;
  logic port_evt;
  logic t0_evt;
  modport src (output ext_evt, output port_evt, output t0_evt);
  modport dst (input ext_evt, input port_evt, input t0_evt);
endinterface : micic_evt_if

//--- rtl/micic_src_detect.sv
// edge, port-change and timer rollover detection
module micic_src_detect
  import micic_pkg::*;
(
  input wire logic clk_in, // core clock
  input wire logic nrst_in, // sync reset, low
  input wire logic ext_int_pin_in, // external pin level
  input wire logic edge_sel_in, // 1 rising, 0 falling
  input wire logic [3:0] upper_port_in, // port pins 7..4
  input wire logic port_read_in, // core reads the port
  input wire logic [7:0] timer0_count_in, // timer0 count
  micic_evt_if.src evt // event strobes
);
  logic pin_q;
  logic [3:0] port_latch_q;
  logic [7:0] t0_prev_q;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_q <= ext_int_pin_in; // start at pin level, no false edge after reset
      t0_prev_q <= 8'h00;
    end else begin
      pin_q <= ext_int_pin_in;
      t0_prev_q <= timer0_count_in;
    end
  end

  // levels kept from the last port read
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      port_latch_q <= upper_port_in; // no false change right after reset
    end else if (port_read_in) begin
      port_latch_q <= upper_port_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      evt.ext_evt <= 1'b0;
      evt.port_evt <= 1'b0;
      evt.t0_evt <= 1'b0;
    end else begin
      evt.ext_evt <= edge_sel_in ? (ext_int_pin_in & ~pin_q) : (~ext_int_pin_in & pin_q);
      evt.port_evt <= |(upper_port_in ^ port_latch_q);
      evt.t0_evt <= (t0_prev_q == 8'hFF) && (timer0_count_in == 8'h00);
    end
  end
endmodule : micic_src_detect

//--- rtl/micic_vector_seq.sv
// instruction-cycle pipeline from pending to vector request
module micic_vector_seq
  import micic_pkg::*;
(
  input wire logic clk_in, // core clock
  input wire logic nrst_in, // sync reset, low
  input wire logic icyc_en_in, // instruction cycle strobe
  input wire logic pend_in, // enabled request with gie
  output logic req_out // vector request to core
);
  logic [LAT_STAGES-1:0] stage_q;

  // one stage per instruction cycle, dropped when the request goes away
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      stage_q <= '0;
    end else if (!pend_in) begin
      stage_q <= '0;
    end else if (icyc_en_in) begin
      stage_q <= {stage_q[LAT_STAGES-2:0], 1'b1};
    end
  end

  assign req_out = stage_q[LAT_STAGES-1] & pend_in;
endmodule : micic_vector_seq

//--- rtl/micic_top.sv
// interrupt controller top: apb registers, flags and vectoring
// Functional notes
// - nine sources: pin, timer0, port, six peripherals
// - flags set regardless of any enable
// - bit 7 global enable gates all vector requests, not wake
// - gie and flagged enabled source request vector
// - reset clears the global enable
// - return from interrupt sets global enable
// - core flags in control, peripherals separate
// - group enable gates all peripheral requests
// - entry clears gie, pushes pc, loads 0004h
// - pin and port latency three or four cycles
// - pin edge chosen by option bit 6
// - pin flag bit 1, enable bit 4
// - pin event wakes core when enabled
// - timer0 FFh to 00h sets bit 2
// - upper port change sets bit 0
// - only return pc saved by hardware
// - enabled interrupt wakes sleep regardless of gie
// - control and peripheral registers reset zero
//
// Chosen here: the APB slave port and the register addresses.
module micic_top
  import micic_pkg::*;
(
  input wire logic ref_clk_in, // 50 MHz clock
  input wire logic nrst_in, // sync reset, low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb access phase
  input wire logic pwrite_in, // apb write
  input wire logic [7:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  input wire logic [3:0] pstrb_in, // apb byte strobes
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error
  input wire logic ext_int_pin_in, // external interrupt pin
  input wire logic [3:0] upper_port_in, // port pins 7..4
  input wire logic port_read_in, // core port read pulse
  input wire logic [7:0] timer0_count_in, // timer0 count
  input wire logic [7:0] periph_evt_in, // peripheral event pulses
  input wire logic int_ack_in, // core accepts vector
  input wire logic return_from_int_in, // core executes return
  input wire logic sleeping_in, // core is asleep
  output logic vector_req_out, // vector request
  output logic vector_entry_out, // push pc and load vector
  output logic [12:0] vector_addr_out, // vector address
  output logic wake_out // wake core from sleep
);
  micic_evt_if evt ();

  micic_qcnt_t qcnt_q;
  logic icyc_en;
  logic [7:0] int_ctrl_q;
  logic [7:0] int_ctrl_d;
  logic [7:0] pflag_q;
  logic [7:0] pflag_d;
  logic [7:0] pen_q;
  logic edge_sel_q;
  logic [7:0] entry_cnt_q;
  logic entry_q;
  logic [12:0] vaddr_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic setup;
  logic wr_en;
  logic wr_ctrl;
  logic wr_pflag;
  logic wr_pen;
  logic wr_opt;
  logic wr_cnt;
  logic mapped;
  logic core_pend;
  logic per_pend;
  logic any_pend;
  logic gie_pend;
  logic vreq;

  // address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = hit(addr, OFS_INT_CONTROL) | hit(addr, OFS_PERIPH_FLAG) |
                hit(addr, OFS_PERIPH_ENABLE) | hit(addr, OFS_OPTION) |
                hit(addr, OFS_STATUS) | hit(addr, OFS_ENTRY_COUNT);
  endfunction : is_mapped

  // instruction cycle strobe, four clocks each
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      qcnt_q <= '0;
    end else if (qcnt_q == micic_qcnt_t'(ICYC_CLKS - 1)) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= qcnt_q + 2'd1;
    end
  end

  assign icyc_en = (qcnt_q == micic_qcnt_t'(ICYC_CLKS - 1));

  micic_src_detect u_detect (
    .clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .ext_int_pin_in(ext_int_pin_in),
    .edge_sel_in(edge_sel_q),
    .upper_port_in(upper_port_in),
    .port_read_in(port_read_in),
    .timer0_count_in(timer0_count_in),
    .evt(evt.src)
  );

  // apb decode; zero wait states
  assign setup = psel_in & ~penable_in;
  assign mapped = is_mapped(paddr_in);
  assign wr_en = psel_in & penable_in & pwrite_in & pstrb_in[0] & mapped;
  assign wr_ctrl = wr_en & hit(paddr_in, OFS_INT_CONTROL);
  assign wr_pflag = wr_en & hit(paddr_in, OFS_PERIPH_FLAG);
  assign wr_pen = wr_en & hit(paddr_in, OFS_PERIPH_ENABLE);
  assign wr_opt = wr_en & hit(paddr_in, OFS_OPTION);
  assign wr_cnt = wr_en & hit(paddr_in, OFS_ENTRY_COUNT);

  // control register next value
  always_comb begin
    int_ctrl_d = int_ctrl_q;
    if (wr_ctrl) begin
      int_ctrl_d = pwdata_in[7:0];
    end
    // hardware clears gie on entry, return sets it again
    if (return_from_int_in) begin
      int_ctrl_d[INT_GIE] = 1'b1;
    end
    if (int_ack_in) begin
      int_ctrl_d[INT_GIE] = 1'b0;
    end
    // event set wins over a software clear in the same cycle
    if (evt.port_evt) begin
      int_ctrl_d[INT_PCF] = 1'b1;
    end
    if (evt.ext_evt) begin
      int_ctrl_d[INT_EXTF] = 1'b1;
    end
    if (evt.t0_evt) begin
      int_ctrl_d[INT_T0F] = 1'b1;
    end
  end

  // flags live beside the enables, set without regard to them
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      int_ctrl_q <= INT_CONTROL_RESET;
    end else begin
      int_ctrl_q <= int_ctrl_d;
    end
  end

  // peripheral flags; unimplemented bits stay zero
  always_comb begin
    pflag_d = pflag_q;
    if (wr_pflag) begin
      pflag_d = pwdata_in[7:0];
    end
    pflag_d = (pflag_d | periph_evt_in) & PF_IMPL_MASK;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      pflag_q <= PERIPH_FLAG_RESET;
    end else begin
      pflag_q <= pflag_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      pen_q <= PERIPH_ENABLE_RESET;
    end else if (wr_pen) begin
      pen_q <= pwdata_in[7:0] & PF_IMPL_MASK;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      edge_sel_q <= EDGE_SEL_RESET;
    end else if (wr_opt) begin
      edge_sel_q <= pwdata_in[OPT_EDGE];
    end
  end

  // pending terms: flags 2..0 pair with enables 5..3
  assign core_pend = |(int_ctrl_q[INT_T0F:INT_PCF] & int_ctrl_q[INT_TIMER0_OVF_ENABLE:INT_PCE]);
  assign per_pend = |(pflag_q & pen_q);
  assign any_pend = core_pend | (int_ctrl_q[INT_PEIE] & per_pend);
  assign gie_pend = int_ctrl_q[INT_GIE] & any_pend;

  micic_vector_seq u_seq (
    .clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .icyc_en_in(icyc_en),
    .pend_in(gie_pend),
    .req_out(vreq)
  );

  assign vector_req_out = vreq;

  // entry strobe tells the core to push only the return pc
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      entry_q <= 1'b0;
    end else begin
      entry_q <= int_ack_in & vreq;
    end
  end

  assign vector_entry_out = entry_q;

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      vaddr_q <= VECTOR_ADDR;
    end else begin
      vaddr_q <= VECTOR_ADDR;
    end
  end

  assign vector_addr_out = vaddr_q;

  // wake ignores gie; gie only decides whether the core vectors
  assign wake_out = sleeping_in & any_pend;

  // count of accepted vectors, write clears
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      entry_cnt_q <= ENTRY_COUNT_RESET;
    end else if (int_ack_in & vreq) begin
      entry_cnt_q <= entry_cnt_q + 8'd1;
    end else if (wr_cnt) begin
      entry_cnt_q <= ENTRY_COUNT_RESET;
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup) begin
      unique case (1'b1)
        hit(paddr_in, OFS_INT_CONTROL): rdata_q <= {24'h00_0000, int_ctrl_q};
        hit(paddr_in, OFS_PERIPH_FLAG): rdata_q <= {24'h00_0000, pflag_q};
        hit(paddr_in, OFS_PERIPH_ENABLE): rdata_q <= {24'h00_0000, pen_q};
        hit(paddr_in, OFS_OPTION): rdata_q <= {24'h00_0000, 1'b0, edge_sel_q, 6'h00};
        hit(paddr_in, OFS_STATUS): rdata_q <= {28'h000_0000, gie_pend, wake_out, sleeping_in, vreq};
        hit(paddr_in, OFS_ENTRY_COUNT): rdata_q <= {24'h00_0000, entry_cnt_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= ~mapped;
    end
  end

  assign prdata_out = rdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & err_q;
endmodule : micic_top

//--- bench/micic_props.sv
// port assertions for the interrupt controller
module micic_props
  import micic_pkg::*;
(
  input wire logic ref_clk_in, // clock
  input wire logic nrst_in, // reset, low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb access
  input wire logic pready_out, // apb ready
  input wire logic pslverr_out, // apb error
  input wire logic int_ack_in, // core ack
  input wire logic sleeping_in, // core asleep
  input wire logic vector_req_out, // request
  input wire logic vector_entry_out, // entry pulse
  input wire logic [12:0] vector_addr_out, // vector
  input wire logic wake_out // wake
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_taken;
    int_ack_in && vector_req_out;
  endsequence
  sequence s_entry;
    vector_entry_out && !vector_req_out;
  endsequence
  entry_on_ack_a: assert property (s_taken |=> s_entry) else $error("no entry after ack");
  entry_cause_a: assert property (vector_entry_out |-> $past(int_ack_in && vector_req_out))
    else $error("entry without ack");
  entry_single_a: assert property (vector_entry_out |=> !vector_entry_out) else $error("entry too long");
  vector_fixed_a: assert property (vector_addr_out == VECTOR_ADDR) else $error("bad vector");
  reset_idle_a: assert property (disable iff (1'b0) !nrst_in |=> !vector_req_out && !wake_out && !vector_entry_out)
    else $error("busy after reset");
  wake_sleep_a: assert property (wake_out |-> sleeping_in) else $error("wake while awake");
  err_access_a: assert property (pslverr_out |-> psel_in && penable_in) else $error("error outside access");
  ready_zero_a: assert property (psel_in && !penable_in |=> pready_out) else $error("wait state seen");
endmodule : micic_props

bind micic_top micic_props i_props (.ref_clk_in, .nrst_in, .psel_in, .penable_in, .pready_out, .pslverr_out,
  .int_ack_in, .sleeping_in, .vector_req_out, .vector_entry_out, .vector_addr_out, .wake_out);

//--- bench/micic_core_model.sv
// core model: takes vector requests and returns from service
module micic_core_model (
  input wire logic clk_in, // core clock
  input wire logic vector_req_in, // request
  input wire logic [1:0] ack_dly_in, // cycles before ack
  output logic int_ack_out, // core takes vector
  output logic return_from_int_out // return pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q = 2'h0;
  initial begin
    int_ack_out = 1'b0;
    return_from_int_out = 1'b0;
  end
  // ack only while the request still stands
  always @(posedge clk_in) begin
    wait_q <= (vector_req_in && !int_ack_out && wait_q != ack_dly_in) ? wait_q + 2'h1 : 2'h0;
    int_ack_out <= vector_req_in && !int_ack_out && wait_q == ack_dly_in;
  end
  // caller clears the flags first
  task do_return;
    @(posedge clk_in);
    return_from_int_out <= 1'b1;
    @(posedge clk_in);
    return_from_int_out <= 1'b0;
  endtask : do_return
endmodule : micic_core_model

//--- bench/mcu_interrupt_controller_test.sv
// self-checking bench for the interrupt controller
module mcu_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  import micic_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pin = 1'b0, prd = 1'b0, slp = 1'b0;
  logic [7:0] pa = 8'h00, t0 = 8'h00, pev = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [3:0] port = 4'h0;
  logic [3:0] strb = 4'h1;
  logic [12:0] vaddr;
  logic entry;
  logic [1:0] dly = 2'h0;
  logic [31:0] prdata, rd;
  logic pready, perr, err, ack, ret, vreq, wake;
  int error_cnt = 0;
  int n_tests = 0;
  int n;
  micic_top i_dut (.ref_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(strb), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .ext_int_pin_in(pin), .upper_port_in(port), .port_read_in(prd), .timer0_count_in(t0),
    .periph_evt_in(pev), .int_ack_in(ack), .return_from_int_in(ret), .sleeping_in(slp),
    .vector_req_out(vreq), .vector_entry_out(entry), .vector_addr_out(vaddr), .wake_out(wake));
  micic_core_model i_core (.clk_in(clk), .vector_req_in(vreq), .ack_dly_in(dly), .int_ack_out(ack),
    .return_from_int_out(ret));
  initial begin
    forever #10 clk = ~clk;
  end
  task end_of_test;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 9; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i == 9) begin
      chk("pready", 1, 0);
      end_of_test();
    end
  endtask : apb
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rchk
  task wait_req;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (vreq !== 1'b1 && n < 40);
    if (n == 40) begin
      chk("vector_req", 1, 0);
      end_of_test();
    end
  endtask : wait_req
  task s_ext(input logic e);
    apb(1'b1, OFS_OPTION, {25'h0, e, 6'h00});
    pin <= !e;
    repeat (4) @(negedge clk);
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_0090);
    pin <= e;
    wait_req();
    chk("latency", 1, n >= 3 * ICYC_CLKS - 2 && n <= 4 * ICYC_CLKS + 2);
    repeat (2) @(negedge clk);
    chk("entry pulse", 1, entry);
    chk("vector addr", VECTOR_ADDR, vaddr);
    repeat (4) @(negedge clk);
    rchk(OFS_INT_CONTROL, 32'h0000_0012);
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_0010);
    i_core.do_return();
    rchk(OFS_INT_CONTROL, 32'h0000_0090);
    pin <= !e;
    repeat (20) @(negedge clk);
    chk("wrong edge", 0, vreq);
  endtask : s_ext
  task s_t0;
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_0020);
    t0 <= 8'hFF;
    @(posedge clk);
    t0 <= 8'h00;
    repeat (20) @(negedge clk);
    chk("req gie off", 0, vreq);
    rchk(OFS_INT_CONTROL, 32'h0000_0024);
    slp <= 1'b1;
    @(negedge clk);
    chk("wake", 1, wake);
    rchk(OFS_STATUS, 32'h0000_0006);
    @(posedge clk);
    slp <= 1'b0;
  endtask : s_t0
  task s_periph;
    dly <= 2'h3;
    apb(1'b1, OFS_PERIPH_ENABLE, 32'h0000_0080);
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_0080);
    pev <= 8'h80;
    @(posedge clk);
    pev <= 8'h00;
    repeat (20) @(negedge clk);
    chk("req group off", 0, vreq);
    rchk(OFS_PERIPH_FLAG, 32'h0000_0080);
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_00C0);
    wait_req();
    repeat (8) @(negedge clk);
    rchk(OFS_ENTRY_COUNT, 32'h0000_0003);
    apb(1'b1, OFS_ENTRY_COUNT, 32'h0000_0000);
    rchk(OFS_ENTRY_COUNT, 32'h0000_0000);
    apb(1'b1, OFS_PERIPH_FLAG, 32'h0000_0000);
  endtask : s_periph
  task s_port;
    prd <= 1'b1;
    @(posedge clk);
    prd <= 1'b0;
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_0008);
    port <= 4'h5;
    repeat (4) @(negedge clk);
    rchk(OFS_INT_CONTROL, 32'h0000_0009);
    prd <= 1'b1;
    @(posedge clk);
    prd <= 1'b0;
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_0008);
    repeat (4) @(negedge clk);
    rchk(OFS_INT_CONTROL, 32'h0000_0008);
  endtask : s_port
  // reset in mid-run with gie set and the pin high
  task s_reset;
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_0080);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk(OFS_INT_CONTROL, 32'h0000_0000);
    rchk(OFS_PERIPH_ENABLE, 32'h0000_0000);
    rchk(OFS_OPTION, 32'h0000_0040);
    strb <= 4'h0;
    apb(1'b1, OFS_INT_CONTROL, 32'h0000_0080);
    strb <= 4'h1;
    rchk(OFS_INT_CONTROL, 32'h0000_0000);
  endtask : s_reset
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rchk(OFS_INT_CONTROL, 32'h0000_0000);
    rchk(OFS_PERIPH_FLAG, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped err", 1, err);
    chk("unmapped rd", 0, rd);
    s_ext(1'b1);
    s_ext(1'b0);
    s_t0();
    s_periph();
    s_port();
    s_reset();
    end_of_test();
  end
endmodule : mcu_interrupt_controller_test
